// ---- hdl/bpsc_defs.svh ----
// Purpose: constants for the bridge port state controller
// Assumes: 50 MHz bridge clock
// Notes:   times are given in their own unit, cycle counts derived
`ifndef BPSC_DEFS_SVH
`define BPSC_DEFS_SVH

// =====================================================================
// timing
`define BPSC_CLK_NS          32'd20
`define BPSC_AGE_LIMIT_MS    32'd2000
`define BPSC_AGE_LIMIT_CYC   ((`BPSC_AGE_LIMIT_MS * 32'd1000000) / `BPSC_CLK_NS)
`define BPSC_RESTART_MS      32'd1000
`define BPSC_RESTART_CYC     ((`BPSC_RESTART_MS * 32'd1000000) / `BPSC_CLK_NS)

// =====================================================================
// state field codes, as read by management
`define BPSC_CODE_INIT       3'h0
`define BPSC_CODE_DISABLED   3'h1
`define BPSC_CODE_BROKEN     3'h2
`define BPSC_CODE_PRE_RELAY  3'h3
`define BPSC_CODE_FORWARDING 3'h4
`define BPSC_CODE_BACKUP     3'h5

// =====================================================================
// path mask bit positions
`define BPSC_PATH_MGMT       0
`define BPSC_PATH_INTO_ENG   1
`define BPSC_PATH_FROM_ENG   2
`define BPSC_PATH_STP        3

`endif

// ---- hdl/bpsc_pkg.sv ----
// Purpose: types for the bridge port state controller
// Assumes: nothing
// Notes:   constants live in bpsc_defs.svh
package bpsc_pkg;

    // =================================================================
    // port operating states
    typedef enum logic [2:0] {
        ST_INIT,
        ST_DISABLED,
        ST_BROKEN,
        ST_PRE_RELAY,
        ST_FORWARDING,
        ST_BACKUP
    } bpsc_state_type;

    // frame source / category
    typedef enum logic [1:0] {
        CAT_MGMT,
        CAT_ENGINE,
        CAT_STP
    } bpsc_cat_type;

    // frame word with framing marks
    typedef struct packed {
        logic [7:0] data;
        logic       sof;
        logic       eof;
        logic       to_self;
    } bpsc_word_type;

    // management commands
    typedef struct packed {
        logic disable_port;
        logic enable_port;
        logic mark_broken;
        logic restart;
    } bpsc_mgmt_cmd_type;

    // spanning-tree control
    typedef struct packed {
        logic go_listen;
        logic go_learn;
        logic go_forward;
        logic go_backup;
    } bpsc_stp_cmd_type;

    // address store request from the forwarding engine
    typedef struct packed {
        logic        valid;
        logic        update;
        logic [47:0] addr;
        logic [3:0]  status;
    } bpsc_addr_req_type;

endpackage : bpsc_pkg

// ---- hdl/bpsc_port.sv ----
// Purpose: per-port operating state and frame path gating of a LAN bridge
// Assumes: one clock at 50 MHz; link pins synchronised here
// Notes:   one outbound word held at a time; its frame's age is checked at start
`timescale 1ns/10ps
`default_nettype none
`include "bpsc_defs.svh"

module bpsc_port
    import bpsc_pkg::*;
#(
    parameter int unsigned AGE_LIMIT_CYC = `BPSC_AGE_LIMIT_CYC,
    parameter int unsigned RESTART_CYC   = `BPSC_RESTART_CYC,
    parameter int unsigned AGE_W         = 32
) (
    // clock and reset
    input  wire  logic              clk,
    input  wire  logic              nrst,
    // link status pins
    input  wire  logic              link_init_fail,
    input  wire  logic              link_init_done,
    input  wire  logic              link_tx_ready,
    // management and tree control
    input  wire  bpsc_mgmt_cmd_type mgmt_cmd,
    input  wire  bpsc_stp_cmd_type  stp_cmd,
    input  wire  logic [AGE_W-1:0]  stp_ageing_cyc,
    // inbound from LAN
    input  wire  bpsc_word_type     rx_word,
    input  wire  logic              rx_valid,
    // outbound frame from modules
    input  wire  bpsc_word_type     out_word,
    input  wire  logic              out_valid,
    input  wire  bpsc_cat_type      out_cat,
    input  wire  logic [AGE_W-1:0]  out_age,
    output logic                    out_ready,
    // engine address store request
    input  wire  bpsc_addr_req_type eng_addr_req,
    input  wire  logic              mgmt_addr_static,
    // delivery to modules
    output bpsc_word_type           to_mgmt_word,
    output logic                    to_mgmt_valid,
    output bpsc_word_type           to_eng_word,
    output logic                    to_eng_valid,
    output bpsc_word_type           to_stp_word,
    output logic                    to_stp_valid,
    // transmit to LAN
    output bpsc_word_type           tx_word,
    output logic                    tx_valid,
    // address store
    output bpsc_addr_req_type       addr_store_req,
    output logic                    addr_store_static,
    output logic [AGE_W-1:0]        addr_ageing_cyc,
    // status
    output logic [2:0]              state_code,
    output logic                    learning_sub,
    output logic                    restart_req,
    output logic                    frame_aged_out
);

    // =================================================================
    // reset release and pin synchronisers
    logic        rst_s1_reg, rst_s2_reg;
    logic [2:0]  pin_s1_reg, pin_s2_reg;
    wire  logic  rst_n = rst_s2_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= 3'h0;
            pin_s2_reg <= 3'h0;
        end else begin
            pin_s1_reg <= {link_tx_ready, link_init_done, link_init_fail};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    wire logic init_fail = pin_s2_reg[0];
    wire logic init_done = pin_s2_reg[1];
    wire logic tx_rdy    = pin_s2_reg[2];

    // =================================================================
    // state machine
    bpsc_state_type state_reg, state_next;
    logic           learn_reg, learn_next;

    always_comb begin
        state_next = state_reg;
        learn_next = learn_reg;
        unique case (state_reg)
            ST_INIT: begin
                if (init_done && !init_fail) begin
                    state_next = ST_PRE_RELAY;
                    learn_next = 1'b0;
                end
            end
            ST_BROKEN: begin
                if (mgmt_cmd.restart) state_next = ST_INIT;
            end
            ST_DISABLED: begin
                if (mgmt_cmd.enable_port) begin
                    state_next = ST_PRE_RELAY;
                    learn_next = 1'b0;
                end
            end
            ST_PRE_RELAY: begin
                // duration held by the tree entity
                if (stp_cmd.go_learn && !learn_reg) learn_next = 1'b1;
                if (stp_cmd.go_forward && learn_reg) state_next = ST_FORWARDING;
                if (stp_cmd.go_backup) state_next = ST_BACKUP;
            end
            ST_FORWARDING: begin
                if (stp_cmd.go_backup) state_next = ST_BACKUP;
            end
            ST_BACKUP: begin
                if (stp_cmd.go_listen) begin
                    state_next = ST_PRE_RELAY;
                    learn_next = 1'b0;
                end
            end
        endcase
        if (state_reg != ST_INIT && state_reg != ST_BROKEN) begin
            if (mgmt_cmd.disable_port) state_next = ST_DISABLED;
            if (mgmt_cmd.mark_broken)  state_next = ST_BROKEN;
        end
        if (init_fail && state_reg != ST_INIT) state_next = ST_INIT;
        if (state_next != ST_PRE_RELAY) learn_next = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_INIT;
            learn_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            learn_reg <= learn_next;
        end
    end

    // =================================================================
    // path gating per state
    function automatic logic [3:0] path_mask(bpsc_state_type s, logic lrn);
        logic [3:0] m;
        m = 4'h0;
        unique case (s)
            ST_INIT:       m = 4'h0;
            ST_DISABLED:   m = 4'h1;
            ST_BROKEN:     m = 4'h0;
            ST_PRE_RELAY:  m = lrn ? 4'hb : 4'h9;
            ST_FORWARDING: m = 4'hf;
            ST_BACKUP:     m = 4'h9;
        endcase
        return m;
    endfunction

    function automatic logic [2:0] state_to_code(bpsc_state_type s);
        logic [2:0] c;
        c = `BPSC_CODE_INIT;
        unique case (s)
            ST_INIT:       c = `BPSC_CODE_INIT;
            ST_DISABLED:   c = `BPSC_CODE_DISABLED;
            ST_BROKEN:     c = `BPSC_CODE_BROKEN;
            ST_PRE_RELAY:  c = `BPSC_CODE_PRE_RELAY;
            ST_FORWARDING: c = `BPSC_CODE_FORWARDING;
            ST_BACKUP:     c = `BPSC_CODE_BACKUP;
        endcase
        return c;
    endfunction

    wire logic [3:0] paths = path_mask(state_reg, learn_reg);
    wire logic listening  = (state_reg == ST_PRE_RELAY) && !learn_reg;
    // listening passes only frames addressed to this port
    wire logic rx_ok      = rx_valid && (!listening || rx_word.to_self);
    wire logic rx_mgmt    = rx_ok && paths[`BPSC_PATH_MGMT];
    wire logic rx_eng     = rx_ok && paths[`BPSC_PATH_INTO_ENG];
    wire logic rx_stp     = rx_ok && paths[`BPSC_PATH_STP];

    // learning only while the engine path in is open
    wire bpsc_addr_req_type addr_req_gated = {
        eng_addr_req.valid && paths[`BPSC_PATH_INTO_ENG],
        eng_addr_req.update, eng_addr_req.addr, eng_addr_req.status};

    // outbound category to path bit
    wire logic out_open =
        (out_cat == CAT_MGMT)   ? paths[`BPSC_PATH_MGMT] :
        (out_cat == CAT_ENGINE) ? paths[`BPSC_PATH_FROM_ENG] :
        (out_cat == CAT_STP)    ? paths[`BPSC_PATH_STP] : 1'b0;

    // =================================================================
    // transmit hold slot with frame ageing
    // single-word slot keeps area tiny; congestion back-pressures the source
    bpsc_word_type    hold_reg;
    logic             hold_full_reg;
    logic [AGE_W-1:0] age_reg;
    logic             hold_sending_reg;

    wire logic take     = out_valid && out_ready;
    // start of destination address ends the age measurement
    wire logic too_old  = hold_full_reg && hold_reg.sof && !hold_sending_reg
                          && (age_reg >= AGE_W'(AGE_LIMIT_CYC));
    wire logic send     = hold_full_reg && tx_rdy && !too_old;
    wire logic drop_cls = out_valid && !out_open;

    // ready is a flop copy of an empty slot; closed-path words are taken and dropped
    wire logic ready_next = !(take && !drop_cls) && !(hold_full_reg && !(send || too_old));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_ready        <= 1'b0;
            hold_reg         <= '0;
            hold_full_reg    <= 1'b0;
            age_reg          <= '0;
            hold_sending_reg <= 1'b0;
        end else begin
            if (take && !drop_cls) begin
                hold_reg      <= out_word;
                hold_full_reg <= 1'b1;
                age_reg       <= out_age;
            end else if (send || too_old) begin
                hold_full_reg <= 1'b0;
            end else if (hold_full_reg) begin
                age_reg <= age_reg + AGE_W'(1);
            end
            if (send) hold_sending_reg <= !hold_reg.eof;
            out_ready <= ready_next;
        end
    end

    // =================================================================
    // broken-state restart timer
    logic [31:0] rst_cnt_reg;
    wire  logic  restart_tick = (state_reg == ST_BROKEN)
                                && (rst_cnt_reg >= RESTART_CYC - 1);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt_reg <= 32'h0;
        end else if (state_reg != ST_BROKEN || restart_tick) begin
            rst_cnt_reg <= 32'h0;
        end else begin
            rst_cnt_reg <= rst_cnt_reg + 32'h1;
        end
    end

    // =================================================================
    // registered outputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            to_mgmt_word      <= '0;
            to_mgmt_valid     <= 1'b0;
            to_eng_word       <= '0;
            to_eng_valid      <= 1'b0;
            to_stp_word       <= '0;
            to_stp_valid      <= 1'b0;
            tx_word           <= '0;
            tx_valid          <= 1'b0;
            addr_store_req    <= '0;
            addr_store_static <= 1'b0;
            addr_ageing_cyc   <= '0;
            state_code        <= `BPSC_CODE_INIT;
            learning_sub      <= 1'b0;
            restart_req       <= 1'b0;
            frame_aged_out    <= 1'b0;
        end else begin
            to_mgmt_word      <= rx_word;
            to_mgmt_valid     <= rx_mgmt;
            to_eng_word       <= rx_word;
            to_eng_valid      <= rx_eng;
            to_stp_word       <= rx_word;
            to_stp_valid      <= rx_stp;
            tx_word           <= hold_reg;
            tx_valid          <= send;
            // learning only while the engine path in is open
            addr_store_req    <= addr_req_gated;
            addr_store_static <= mgmt_addr_static;
            addr_ageing_cyc   <= stp_ageing_cyc;
            state_code        <= state_to_code(state_reg);
            learning_sub      <= learn_reg;
            restart_req       <= restart_tick;
            frame_aged_out    <= too_old;
        end
    end

    // =================================================================
    // checks
    a_broken_all_closed: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_BROKEN) |=> !to_mgmt_valid && !to_eng_valid && !to_stp_valid)
        else $error("broken port delivered a frame");
    a_init_no_path: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_INIT) |=> !to_mgmt_valid && !to_eng_valid && !to_stp_valid)
        else $error("init port delivered a frame");
    a_disabled_mgmt_only: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_DISABLED && rx_valid) |=> to_mgmt_valid && !to_eng_valid
            && !to_stp_valid)
        else $error("disabled port path wrong");
    a_listen_no_engine: assert property (@(posedge clk) disable iff (!rst_n)
        listening |=> !to_eng_valid)
        else $error("listening port fed the engine");
    a_learn_into_engine: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_PRE_RELAY && learn_reg && rx_valid) |=> to_eng_valid)
        else $error("learning port did not feed engine");
    a_forward_all_open: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_FORWARDING && rx_valid) |=> to_mgmt_valid && to_eng_valid
            && to_stp_valid)
        else $error("forwarding port path closed");
    a_backup_paths: assert property (@(posedge clk) disable iff (!rst_n)
        (state_reg == ST_BACKUP && rx_valid) |=> !to_eng_valid && to_stp_valid)
        else $error("backup port path wrong");
    a_fail_to_init: assert property (@(posedge clk) disable iff (!rst_n)
        (init_fail && state_reg != ST_INIT) |=> state_reg == ST_INIT)
        else $error("init failure ignored");
    a_learn_order: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(state_reg == ST_PRE_RELAY) |-> !learn_reg)
        else $error("pre-relay entered in learning");
    a_aged_not_sent: assert property (@(posedge clk) disable iff (!rst_n)
        too_old |=> !tx_valid && frame_aged_out)
        else $error("aged frame transmitted");

endmodule : bpsc_port
`default_nettype wire

// ---- verif/bpsc_link_model.sv ----
// Purpose: behavioural model of the attached LAN data link
// Assumes: bench clock; the port synchronises these pins itself
// Notes:   mode 0 always ready, 1 ready one cycle in four, 2 stalled
`timescale 1ns/10ps
`default_nettype none
module bpsc_link_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // bench control
    input  wire logic [1:0] mode,
    input  wire logic       fail_req,
    // link status pins
    output logic            link_init_fail,
    output logic            link_init_done,
    output logic            link_tx_ready
);
    // =================================================================
    // self-test span
    logic [3:0] test_reg;
    logic [1:0] phase_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            test_reg  <= 4'h0;
            phase_reg <= 2'h0;
        end else begin
            if (test_reg != 4'hf) test_reg <= test_reg + 4'h1;
            phase_reg <= phase_reg + 2'h1;
        end
    end
    // a failing link never reports done, so the port cannot leave init
    assign link_init_done = (test_reg == 4'hf) && !fail_req;
    assign link_init_fail = fail_req;
    // congestion: ready withheld so the port must keep its frame
    assign link_tx_ready = (mode == 2'h0) || ((mode == 2'h1) && (phase_reg == 2'h0));
endmodule // bpsc_link_model
`default_nettype wire

// ---- verif/tb_bpsc_port.sv ----
// Purpose: self-checking bench for the bridge port state controller
// Assumes: shortened age limit 50 and restart period 20
// Notes:   expected results are queued; a monitor pops and compares
`timescale 1ns/10ps
`default_nettype none
`include "bpsc_defs.svh"
module tb_bpsc_port import bpsc_pkg::*; ;
    typedef struct packed {
        logic [3:0]        mask;
        bpsc_word_type     w;
        bpsc_addr_req_type a;
        logic              st;
    } bpsc_note_type;
    // =================================================================
    // signals
    logic              clk, nrst, fail_req, rx_valid, out_valid, out_ready, mgmt_addr_static;
    logic              link_init_fail, link_init_done, link_tx_ready, lst;
    logic              to_mgmt_valid, to_eng_valid, to_stp_valid, tx_valid;
    logic              addr_store_static, learning_sub, restart_req, frame_aged_out;
    logic [1:0]        mode;
    logic [2:0]        state_code;
    logic [3:0]        cur_mask;
    logic [31:0]       stp_ageing_cyc, out_age, addr_ageing_cyc;
    logic [31:0]       seed = 32'h00000df6;
    logic              rx_due = 1'b0;
    bpsc_mgmt_cmd_type mgmt_cmd;
    bpsc_stp_cmd_type  stp_cmd;
    bpsc_cat_type      out_cat;
    bpsc_addr_req_type eng_addr_req, addr_store_req;
    bpsc_word_type     rx_word, out_word, to_mgmt_word, to_eng_word, to_stp_word, tx_word, tw;
    bpsc_note_type     note_q[$], nt;
    bpsc_word_type     tx_q[$];
    int                bad_count, total_checks, aged_seen;

    bpsc_port #(.AGE_LIMIT_CYC(50), .RESTART_CYC(20)) u_bpsc_port (
        .clk, .nrst, .link_init_fail, .link_init_done, .link_tx_ready, .mgmt_cmd, .stp_cmd,
        .stp_ageing_cyc, .rx_word, .rx_valid, .out_word, .out_valid, .out_cat, .out_age,
        .out_ready, .eng_addr_req, .mgmt_addr_static, .to_mgmt_word, .to_mgmt_valid,
        .to_eng_word, .to_eng_valid, .to_stp_word, .to_stp_valid, .tx_word, .tx_valid,
        .addr_store_req, .addr_store_static, .addr_ageing_cyc, .state_code, .learning_sub,
        .restart_req, .frame_aged_out);
    bpsc_link_model u_bpsc_link_model (
        .clk, .nrst, .mode, .fail_req, .link_init_fail, .link_init_done, .link_tx_ready);

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // =================================================================
    // helpers
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic quiet();
        rx_valid = 1'b0;
        eng_addr_req.valid = 1'b0;
        out_valid = 1'b0;
        tick(1);
    endtask
    // rx_valid stays up after each call so back-to-back words arrive with no gap; quiet() drops it
    task automatic rx_send(input logic self);
        bpsc_note_type n;
        logic [31:0]   r;
        r = xs();
        n.w = {r[7:0], 1'b1, 1'b1, self};
        n.a = {1'b1, r[8], xs(), r[31:16], r[12:9]};
        n.st = r[13];
        n.mask = (lst && !self) ? 4'h0 : cur_mask;
        rx_word = n.w;
        eng_addr_req = n.a;
        mgmt_addr_static = n.st;
        rx_valid = 1'b1;
        note_q.push_back(n);
        tick(1);
    endtask
    task automatic out_send(input logic [1:0] cat, input logic [31:0] age, input logic exp);
        logic [31:0] r;
        logic        rdy;
        int          k;
        r = xs();
        out_word = {r[7:0], 3'h6};
        out_cat = bpsc_cat_type'(cat);
        out_age = age;
        out_valid = 1'b1;
        rdy = 1'b0;
        for (k = 0; k < 60 && !rdy; k++) begin
            @(negedge clk);
            rdy = out_ready;
            @(posedge clk);
        end
        #1;
        check(rdy, 1'b1);
        if (rdy && exp) tx_q.push_back(out_word);
    endtask
    task automatic exercise();
        int c;
        rx_send(1'b1);
        rx_send(1'b0);
        quiet();
        for (c = 0; c < 3; c++) out_send(c[1:0], xs() & 32'hf, cur_mask[(c == 0) ? 0 : c + 1]);
        quiet();
        tick(8);
    endtask
    task automatic cmd(input logic [7:0] v, input logic [2:0] code, input logic lrn,
                       input logic [3:0] m);
        {mgmt_cmd, stp_cmd} = v;
        tick(1);
        {mgmt_cmd, stp_cmd} = 8'h00;
        tick(3);
        check(state_code, code);
        check(learning_sub, lrn);
        cur_mask = m;
        lst = (code == `BPSC_CODE_PRE_RELAY) && !lrn;
        exercise();
    endtask
    task automatic wait_code(input logic [2:0] code);
        int k;
        for (k = 0; k < 40 && state_code !== code; k++) tick(1);
        check(state_code, code);
    endtask
    task automatic count_restart(input int exp);
        int n;
        n = 0;
        repeat (40) begin
            tick(1);
            if (restart_req === 1'b1) n++;
        end
        check(n, exp);
    endtask
    // =================================================================
    // monitor
    always @(posedge clk) begin
        if (rx_due) begin
            nt = note_q.pop_front();
            check(to_mgmt_valid, nt.mask[`BPSC_PATH_MGMT]);
            check(to_eng_valid, nt.mask[`BPSC_PATH_INTO_ENG]);
            check(to_stp_valid, nt.mask[`BPSC_PATH_STP]);
            check(addr_store_req.valid, nt.mask[`BPSC_PATH_INTO_ENG]);
            if (nt.mask[`BPSC_PATH_INTO_ENG]) check(addr_store_req, nt.a);
            if (nt.mask[`BPSC_PATH_MGMT]) check(to_mgmt_word, nt.w);
            if (nt.mask[`BPSC_PATH_INTO_ENG]) check(to_eng_word, nt.w);
            if (nt.mask[`BPSC_PATH_STP]) check(to_stp_word, nt.w);
            check(addr_store_static, nt.st);
        end
        if (tx_valid === 1'b1) begin
            if (tx_q.size() == 0) check(1'b1, 1'b0);
            else begin
                tw = tx_q.pop_front();
                check(tx_word, tw);
            end
        end
        if (frame_aged_out === 1'b1) aged_seen++;
        rx_due <= rx_valid;
    end
    // =================================================================
    // main sequence
    initial begin
        {nrst, fail_req, rx_valid, out_valid, mgmt_addr_static, lst} = 6'h00;
        {mgmt_cmd, stp_cmd, mode, cur_mask, out_age} = '0;
        {rx_word, out_word, eng_addr_req} = '0;
        out_cat = CAT_MGMT;
        stp_ageing_cyc = xs();
        tick(4);
        check(state_code, `BPSC_CODE_INIT);
        nrst = 1'b1;
        wait_code(`BPSC_CODE_PRE_RELAY);
        cur_mask = 4'h9;
        lst = 1'b1;
        exercise();
        cmd(8'h04, `BPSC_CODE_PRE_RELAY, 1'b1, 4'hb);
        cmd(8'h02, `BPSC_CODE_FORWARDING, 1'b0, 4'hf);
        count_restart(0);
        cmd(8'h01, `BPSC_CODE_BACKUP, 1'b0, 4'h9);
        cmd(8'h08, `BPSC_CODE_PRE_RELAY, 1'b0, 4'h9);
        cmd(8'h80, `BPSC_CODE_DISABLED, 1'b0, 4'h1);
        cmd(8'h40, `BPSC_CODE_PRE_RELAY, 1'b0, 4'h9);
        cmd(8'h20, `BPSC_CODE_BROKEN, 1'b0, 4'h0);
        count_restart(2);
        cmd(8'h10, `BPSC_CODE_PRE_RELAY, 1'b0, 4'h9);
        cmd(8'h04, `BPSC_CODE_PRE_RELAY, 1'b1, 4'hb);
        cmd(8'h02, `BPSC_CODE_FORWARDING, 1'b0, 4'hf);
        // congested link: every frame must still leave, in order
        mode = 2'h1;
        repeat (6) out_send(2'h1, xs() & 32'h7, 1'b1);
        quiet();
        tick(40);
        // a frame held past the limit must never reach the wire
        mode = 2'h2;
        tick(5);
        out_send(2'h1, 32'd45, 1'b0);
        quiet();
        tick(20);
        mode = 2'h0;
        tick(10);
        out_send(2'h1, 32'd50, 1'b0);
        out_send(2'h1, 32'd30, 1'b1);
        quiet();
        tick(10);
        fail_req = 1'b1;
        wait_code(`BPSC_CODE_INIT);
        cur_mask = 4'h0;
        lst = 1'b0;
        exercise();
        fail_req = 1'b0;
        wait_code(`BPSC_CODE_PRE_RELAY);
        tick(10);
        check(note_q.size() + tx_q.size(), 0);
        check(aged_seen, 2);
        check(addr_ageing_cyc, stp_ageing_cyc);
        complete_run();
    end
    initial begin
        #400000;
        bad_count++;
        complete_run();
    end
endmodule // tb_bpsc_port
`default_nettype wire
